// *** bench/ifeb_src_model.sv ***
// Peripheral request sources and partner registers facing the flag bank
`timescale 1ns/100ps
`default_nettype none
module ifeb_src_model
(
  // Command from the bench
  input wire logic fire,
  input wire logic [2:0] sel,
  input wire logic [15:0] ev_mask,
  input wire logic [15:0] ext_val,
  // Request lines toward the bank
  output logic [15:0] src_set_1,
  output logic [15:0] src_set_2,
  output logic [15:0] src_set_3,
  output logic [15:0] src_set_4,
  // Partner flags and enables held elsewhere
  output logic [15:0] ext_flags_0,
  output logic [15:0] ext_enables_1,
  output logic [15:0] ext_enables_2,
  output logic [15:0] ext_enables_3,
  output logic [15:0] ext_enables_4
);
  // A source raises its request only while the bench fires it
  assign src_set_1 = (fire && sel == 3'd1) ? ev_mask : 16'h0000;
  assign src_set_2 = (fire && sel == 3'd2) ? ev_mask : 16'h0000;
  assign src_set_3 = (fire && sel == 3'd3) ? ev_mask : 16'h0000;
  assign src_set_4 = (fire && sel == 3'd4) ? ev_mask : 16'h0000;
  // Partner flags and enables all follow the one bench value ext_val
  assign ext_flags_0 = ext_val;
  assign ext_enables_1 = ext_val;
  assign ext_enables_2 = ext_val;
  assign ext_enables_3 = ext_val;
  assign ext_enables_4 = ext_val;
endmodule
`default_nettype wire

// *** bench/tb_interrupt_flag_enable_bank.sv ***
// Self-checking bench of the interrupt flag and enable bank
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_flag_enable_bank
  import ifeb_pkg::*;
;
  // Bus master side
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // Partner command and wiring
  logic fire = 1'b0;
  logic [2:0] sel = 3'd0;
  logic [15:0] ev_mask = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] src [1:4];
  logic [15:0] ee [1:4];
  logic [15:0] fl [1:4];
  logic [15:0] rq [0:4];
  logic [15:0] ef0, en0;
  int n_mismatch = 0;
  int total_checks = 0;
  // Register offsets and implemented bits per flag register
  localparam logic [7:0] OFFS [1:4] = '{OFFS_FLAGS_1, OFFS_FLAGS_2, OFFS_FLAGS_3, OFFS_FLAGS_4};
  localparam logic [15:0] IMPL [1:4] = '{IMPL_FLAGS_1, IMPL_FLAGS_2, IMPL_FLAGS_3, IMPL_FLAGS_4};

  // 10 MHz clock
  always #50 aclk = ~aclk;

  ifeb_top dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_set_1(src[1]), .src_set_2(src[2]), .src_set_3(src[3]), .src_set_4(src[4]),
    .ext_flags_0(ef0), .ext_enables_1(ee[1]), .ext_enables_2(ee[2]),
    .ext_enables_3(ee[3]), .ext_enables_4(ee[4]),
    .flags_1(fl[1]), .flags_2(fl[2]), .flags_3(fl[3]), .flags_4(fl[4]), .enables_0(en0),
    .req_0(rq[0]), .req_1(rq[1]), .req_2(rq[2]), .req_3(rq[3]), .req_4(rq[4]), .irq(irq));

  ifeb_src_model partner (.fire(fire), .sel(sel), .ev_mask(ev_mask), .ext_val(ext_val),
    .src_set_1(src[1]), .src_set_2(src[2]), .src_set_3(src[3]), .src_set_4(src[4]),
    .ext_flags_0(ef0), .ext_enables_1(ee[1]), .ext_enables_2(ee[2]),
    .ext_enables_3(ee[3]), .ext_enables_4(ee[4]));

  // Verdict and end of run
  task automatic tally_and_finish;
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compare one value, report a mismatch at once
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bounded wait ran out
  task automatic hang;
    n_mismatch++;
    tally_and_finish;
  endtask

  // Write one word, each channel released when taken, then check bresp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 50) hang;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  // Read one word
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 50) hang;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Read and compare a mapped register
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", 32'(RESP_OKAY), 32'(r));
  endtask

  // One-cycle source pulse, returns once the flag is visible
  task automatic pulse(input logic [2:0] s, input logic [15:0] m);
    @(posedge aclk);
    sel <= s;
    ev_mask <= m;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    tick(1);
  endtask

  // Flags, enables and interrupt mask read zero after reset
  task automatic t_reset;
    for (int i = 1; i <= 4; i++)
      rc("flags_rst", OFFS[i], 32'h0000_0000);
    rc("enables_rst", OFFS_ENABLES_0, 32'h0000_0000);
    rc("mask_rst", OFFS_IRQ_MASK, 32'h0000_0000);
  endtask

  // Software sets and clears; absent bits stay zero
  task automatic t_sw;
    for (int i = 1; i <= 4; i++)
    begin
      wr(OFFS[i], 32'hFFFF_FFFF, RESP_OKAY);
      rc("flags_sw", OFFS[i], 32'(IMPL[i]));
      chk("flags_port", 32'(IMPL[i]), 32'(fl[i]));
      wr(OFFS[i], 32'h0000_0000, RESP_OKAY);
      rc("flags_clr", OFFS[i], 32'h0000_0000);
    end
    wr(OFFS_ENABLES_0, 32'hFFFF_FFFF, RESP_OKAY);
    rc("enables", OFFS_ENABLES_0, 32'(IMPL_ENABLES_0));
    chk("enables_port", 32'(IMPL_ENABLES_0), 32'(en0));
    // Low byte lane only: high byte of the register keeps its value
    wstrb <= 4'h1;
    wr(OFFS_FLAGS_1, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rc("flags_lane", OFFS_FLAGS_1, 32'(IMPL_FLAGS_1 & 16'h00FF));
    wr(OFFS_FLAGS_1, 32'h0000_0000, RESP_OKAY);
  endtask

  // Requests need both flag and enable
  task automatic t_req;
    @(posedge aclk);
    ext_val <= 16'hFFFF;
    tick(3);
    chk("req_0", 32'(IMPL_ENABLES_0), 32'(rq[0]));
    chk("req_1", 32'h0000_0000, 32'(rq[1]));
    wr(OFFS_ENABLES_0, 32'h0000_0100, RESP_OKAY);
    tick(2);
    chk("req_0_gate", 32'h0000_0100, 32'(rq[0]));
  endtask

  // Hardware set, status, summary interrupt and its clear on read
  task automatic t_src;
    logic [31:0] d;
    logic [1:0] r;
    rd(OFFS_IRQ_STATUS, d, r);
    chk("status_idle", 32'h0000_0000, d);
    wr(OFFS_IRQ_MASK, 32'h0000_000F, RESP_OKAY);
    rc("mask", OFFS_IRQ_MASK, 32'h0000_000F);
    chk("irq_idle", 32'h0, 32'(irq));
    for (int i = 1; i <= 4; i++)
    begin
      pulse(3'(i), 16'hFFFF);
      tick(1);
      chk("flags_hw", 32'(IMPL[i]), 32'(fl[i]));
      chk("req_n", 32'(IMPL[i]), 32'(rq[i]));
      chk("irq_up", 32'h1, 32'(irq));
      rc("status", OFFS_IRQ_STATUS, 32'h1 << (i - 1));
      tick(1);
      chk("irq_clr", 32'h0, 32'(irq));
    end
    // Masked event: status still sticks, summary interrupt stays low
    wr(OFFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    pulse(3'd1, 16'hFFFF);
    chk("irq_masked", 32'h0, 32'(irq));
    rc("status_masked", OFFS_IRQ_STATUS, 32'h0000_0001);
    @(posedge aclk);
    ext_val <= 16'h0000;
    tick(3);
    chk("req_off", 32'h0000_0000, 32'(rq[4]));
  endtask

  // Unmapped address is refused
  task automatic t_bad;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h1C, d, r);
    chk("bad_data", 32'h0000_0000, d);
    chk("bad_resp", 32'(RESP_SLVERR), 32'(r));
  endtask

  // Main sequence
  initial
  begin
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    t_reset;
    t_sw;
    t_req;
    t_src;
    t_bad;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** logic/ifeb_axil_slave.sv ***
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module ifeb_axil_slave
  import ifeb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side strobes
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data
);

  // All slave state
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } ifeb_axil_state_type;

  // Idle slave: both write channels and the read channel open
  localparam ifeb_axil_state_type AXIL_RESET = '{1'b1, 1'b1, 1'b1, 1'b0, RESP_OKAY,
    1'b0, RESP_OKAY, 32'h0000_0000, 8'h00, 32'h0000_0000, 4'h0};

  ifeb_axil_state_type state_reg;
  ifeb_axil_state_type state_next;

  // Write fires once both halves are held and no response is pending
  assign wr_en = !state_reg.awready && !state_reg.wready && !state_reg.bvalid;
  assign wr_addr = state_reg.awaddr;
  assign wr_data = state_reg.wdata;
  assign wr_strb = state_reg.wstrb;
  // Read fires on the address handshake itself
  assign rd_en = arvalid && state_reg.arready;
  assign rd_addr = araddr;

  // Channel handshakes
  always_comb
  begin
    state_next = state_reg;
    // Capture write address, close channel until response done
    if (awvalid && state_reg.awready)
    begin
      state_next.awaddr = awaddr;
      state_next.awready = 1'b0;
    end
    // Capture write data independently of the address
    if (wvalid && state_reg.wready)
    begin
      state_next.wdata = wdata;
      state_next.wstrb = wstrb;
      state_next.wready = 1'b0;
    end
    // Both halves held: perform write and answer
    if (wr_en)
    begin
      state_next.bvalid = 1'b1;
      state_next.bresp = addr_known(state_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // Response taken: reopen both write channels
    if (state_reg.bvalid && bready)
    begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end
    // Read: latch data in the handshake cycle
    if (rd_en)
    begin
      state_next.rdata = rd_data;
      state_next.rresp = addr_known(araddr) ? RESP_OKAY : RESP_SLVERR;
      state_next.rvalid = 1'b1;
      state_next.arready = 1'b0;
    end
    // Read data taken: reopen read address channel
    if (state_reg.rvalid && rready)
    begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= AXIL_RESET;
    else
      state_reg <= state_next;
  end

  // Outputs straight from the state
  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign arready = state_reg.arready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign rvalid = state_reg.rvalid;
  assign rresp = state_reg.rresp;
  assign rdata = state_reg.rdata;

endmodule
`default_nettype wire

// *** logic/ifeb_flag_reg.sv ***
// One 16-bit register with software write, hardware set and fixed unimplemented bits
`timescale 1ns/100ps
`default_nettype none
module ifeb_flag_reg
  import ifeb_pkg::*;
#(
  // Bits that exist in this register
  parameter logic [15:0] IMPL = 16'hFFFF
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Software write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wr_mask,
  // Hardware set requests
  input wire logic [15:0] src_set,
  // Register value and set indication
  output logic [15:0] flags,
  output logic set_seen
);

  // Register state
  typedef struct packed {
    logic [15:0] flags;
  } ifeb_flag_state_type;

  ifeb_flag_state_type state_reg;
  ifeb_flag_state_type state_next;

  // Any implemented source asking this cycle
  assign set_seen = |(src_set & IMPL);

  // Write replaces selected bytes, then sets are OR-ed so they beat a clear
  always_comb
  begin
    state_next = state_reg;
    if (wr_en)
      state_next.flags = (state_reg.flags & ~wr_mask) | (wr_data & wr_mask);
    state_next.flags = (state_next.flags | src_set) & IMPL;
  end

  // Register with synchronous reset to zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '{flags: RESET_REG};
    else
      state_reg <= state_next;
  end

  assign flags = state_reg.flags;

endmodule
`default_nettype wire

// *** logic/ifeb_pkg.sv ***
// Shared constants, register map and helper functions of the interrupt flag and enable bank
package ifeb_pkg;

  // Data width of one flag or enable register
  localparam int REG_W = 16;
  // Width of the AXI4-Lite byte address
  localparam int ADDR_W = 8;
  // Number of sticky bits in the interrupt status register
  localparam int IRQ_W = 4;

  // Byte offsets of the registers on the bus
  localparam logic [7:0] OFFS_FLAGS_1 = 8'h00;
  localparam logic [7:0] OFFS_FLAGS_2 = 8'h04;
  localparam logic [7:0] OFFS_FLAGS_3 = 8'h08;
  localparam logic [7:0] OFFS_FLAGS_4 = 8'h0C;
  localparam logic [7:0] OFFS_ENABLES_0 = 8'h10;
  localparam logic [7:0] OFFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFFS_IRQ_MASK = 8'h18;

  // Implemented bits: uart2 tx/rx, ext input 2, timer5/4, compare4/3 at 15..9;
  // ext input 1, change notice, comparator, i2c1 master/slave at 4..0
  localparam logic [15:0] IMPL_FLAGS_1 = 16'hFE1F;
  // Parallel port 13, compare5 9, capture5/4/3 7..5, spi2 event 1, spi2 fault 0
  localparam logic [15:0] IMPL_FLAGS_2 = 16'h22E3;
  // Calendar 14, i2c2 master 2, i2c2 slave 1
  localparam logic [15:0] IMPL_FLAGS_3 = 16'h4006;
  // Low voltage 8, checksum generator 3, uart2 error 2, uart1 error 1
  localparam logic [15:0] IMPL_FLAGS_4 = 16'h010E;
  // Adc done, uart1 tx/rx, spi1 done/fault, timer3 at 13..8; timer2, compare2,
  // capture2 at 7..5; timer1, compare1, capture1, ext input 0 at 3..0
  localparam logic [15:0] IMPL_ENABLES_0 = 16'h3FEF;

  // Reset values
  localparam logic [15:0] RESET_REG = 16'h0000;
  localparam logic [3:0] RESET_IRQ = 4'h0;

  // Status bit of each flag register in the interrupt status register
  localparam int IRQ_BIT_FLAGS_1 = 0;
  localparam int IRQ_BIT_FLAGS_2 = 1;
  localparam int IRQ_BIT_FLAGS_3 = 2;
  localparam int IRQ_BIT_FLAGS_4 = 3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // True when a byte address falls in the word of a register offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offs);
    return addr[7:2] == offs[7:2];
  endfunction

  // True when a byte address selects any mapped register
  function automatic logic addr_known(input logic [7:0] addr);
    return addr[7:2] <= OFFS_IRQ_MASK[7:2];
  endfunction

  // Expand the two low byte strobes into a bit mask of one register
  function automatic logic [15:0] strb_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

endpackage

// *** logic/ifeb_top.sv ***
// Interrupt flag and enable bank with AXI4-Lite access and a summary interrupt
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module ifeb_top
  import ifeb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral request pulses, one bit per flag position
  input wire logic [15:0] src_set_1,
  input wire logic [15:0] src_set_2,
  input wire logic [15:0] src_set_3,
  input wire logic [15:0] src_set_4,
  // Partner registers held elsewhere in the unit
  input wire logic [15:0] ext_flags_0,
  input wire logic [15:0] ext_enables_1,
  input wire logic [15:0] ext_enables_2,
  input wire logic [15:0] ext_enables_3,
  input wire logic [15:0] ext_enables_4,
  // Register contents toward the rest of the unit
  output logic [15:0] flags_1,
  output logic [15:0] flags_2,
  output logic [15:0] flags_3,
  output logic [15:0] flags_4,
  output logic [15:0] enables_0,
  // Flag-and-enable requests toward priority arbitration
  output logic [15:0] req_0,
  output logic [15:0] req_1,
  output logic [15:0] req_2,
  output logic [15:0] req_3,
  output logic [15:0] req_4,
  // Summary interrupt
  output logic irq
);

  // Own state: summary interrupt and registered requests
  typedef struct packed {
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic irq;
    logic [15:0] req_0;
    logic [15:0] req_1;
    logic [15:0] req_2;
    logic [15:0] req_3;
    logic [15:0] req_4;
  } ifeb_top_state_type;

  ifeb_top_state_type state_reg;
  ifeb_top_state_type state_next;

  // Register strobes from the bus slave
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  // Low half of the write data and its byte mask
  logic [15:0] wr_low;
  logic [15:0] wr_mask;
  // Hardware set seen per flag register
  logic [3:0] events;

  assign wr_low = wr_data[15:0];
  assign wr_mask = strb_mask(wr_strb);

  // Bus front end
  ifeb_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Flag registers: sources set, software writes, absent bits forced low
  ifeb_flag_reg #(.IMPL(IMPL_FLAGS_1)) u_flags_1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && reg_hit(wr_addr, OFFS_FLAGS_1)),
    .wr_data(wr_low),
    .wr_mask(wr_mask),
    .src_set(src_set_1),
    .flags(flags_1),
    .set_seen(events[IRQ_BIT_FLAGS_1])
  );

  ifeb_flag_reg #(.IMPL(IMPL_FLAGS_2)) u_flags_2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && reg_hit(wr_addr, OFFS_FLAGS_2)),
    .wr_data(wr_low),
    .wr_mask(wr_mask),
    .src_set(src_set_2),
    .flags(flags_2),
    .set_seen(events[IRQ_BIT_FLAGS_2])
  );

  ifeb_flag_reg #(.IMPL(IMPL_FLAGS_3)) u_flags_3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && reg_hit(wr_addr, OFFS_FLAGS_3)),
    .wr_data(wr_low),
    .wr_mask(wr_mask),
    .src_set(src_set_3),
    .flags(flags_3),
    .set_seen(events[IRQ_BIT_FLAGS_3])
  );

  ifeb_flag_reg #(.IMPL(IMPL_FLAGS_4)) u_flags_4 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && reg_hit(wr_addr, OFFS_FLAGS_4)),
    .wr_data(wr_low),
    .wr_mask(wr_mask),
    .src_set(src_set_4),
    .flags(flags_4),
    .set_seen(events[IRQ_BIT_FLAGS_4])
  );

  // Enable register: software only, no hardware set
  ifeb_flag_reg #(.IMPL(IMPL_ENABLES_0)) u_enables_0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && reg_hit(wr_addr, OFFS_ENABLES_0)),
    .wr_data(wr_low),
    .wr_mask(wr_mask),
    .src_set(RESET_REG),
    .flags(enables_0),
    .set_seen()
  );

  // Read multiplexer; upper half and absent bits always zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr[7:2])
      OFFS_FLAGS_1[7:2]: rd_data[15:0] = flags_1;
      OFFS_FLAGS_2[7:2]: rd_data[15:0] = flags_2;
      OFFS_FLAGS_3[7:2]: rd_data[15:0] = flags_3;
      OFFS_FLAGS_4[7:2]: rd_data[15:0] = flags_4;
      OFFS_ENABLES_0[7:2]: rd_data[15:0] = enables_0;
      OFFS_IRQ_STATUS[7:2]: rd_data[3:0] = state_reg.irq_status;
      OFFS_IRQ_MASK[7:2]: rd_data[3:0] = state_reg.irq_mask;
      // Unmapped words read as zero with an error response
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Summary interrupt and request pairing
  always_comb
  begin
    state_next = state_reg;
    // Reading status clears it; new events in the same cycle survive
    if (rd_en && reg_hit(rd_addr, OFFS_IRQ_STATUS))
      state_next.irq_status = RESET_IRQ;
    state_next.irq_status = state_next.irq_status | events;
    // Mask is written from the low byte
    if (wr_en && reg_hit(wr_addr, OFFS_IRQ_MASK) && wr_strb[0])
      state_next.irq_mask = wr_data[3:0];
    // Level output follows unmasked status
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    // Requests pass only where flag and enable are both set
    state_next.req_0 = ext_flags_0 & enables_0;
    state_next.req_1 = flags_1 & ext_enables_1;
    state_next.req_2 = flags_2 & ext_enables_2;
    state_next.req_3 = flags_3 & ext_enables_3;
    state_next.req_4 = flags_4 & ext_enables_4;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= '{RESET_IRQ, RESET_IRQ, 1'b0, RESET_REG, RESET_REG, RESET_REG,
        RESET_REG, RESET_REG};
    else
      state_reg <= state_next;
  end

  // Outputs from the state
  assign irq = state_reg.irq;
  assign req_0 = state_reg.req_0;
  assign req_1 = state_reg.req_1;
  assign req_2 = state_reg.req_2;
  assign req_3 = state_reg.req_3;
  assign req_4 = state_reg.req_4;

  // Checks on the register bank
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Full-word write of flags 1 with no source active
  sequence s_flags1_write;
    wr_en && reg_hit(wr_addr, OFFS_FLAGS_1) && wr_strb == 4'hF && src_set_1 == RESET_REG;
  endsequence

  // Source pulse on flags 1
  sequence s_flags1_set;
    (src_set_1 & IMPL_FLAGS_1) != RESET_REG;
  endsequence

  // Written value lands masked by the implemented bits
  property p_flag_write;
    s_flags1_write |=> flags_1 == ($past(wr_low) & IMPL_FLAGS_1);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("flag write lost");

  // Source set reaches the flag even against a clearing write
  property p_flag_set;
    s_flags1_set |=> (flags_1 & $past(src_set_1) & IMPL_FLAGS_1) ==
      ($past(src_set_1) & IMPL_FLAGS_1);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set lost");

  // Enable write lands masked by the implemented bits
  property p_enable_write;
    wr_en && reg_hit(wr_addr, OFFS_ENABLES_0) && wr_strb == 4'hF |=>
      enables_0 == ($past(wr_low) & IMPL_ENABLES_0);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  // Read data upper half is zero once the answer stands, one edge after the read
  property p_read_upper;
    rd_en |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read bits set");

  // Reset leaves all flags and enables clear
  property p_reset_clear;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (flags_1 | flags_2 | flags_3 | flags_4 | enables_0) == RESET_REG;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");

  // Absent bits of flags 1 stay low
  property p_flags1_absent;
    (flags_1 & ~IMPL_FLAGS_1) == RESET_REG;
  endproperty
  a_flags1_absent: assert property (p_flags1_absent) else $error("flags 1 absent bit");

  // Absent bits of flags 2 stay low
  property p_flags2_absent;
    (flags_2 & ~IMPL_FLAGS_2) == RESET_REG;
  endproperty
  a_flags2_absent: assert property (p_flags2_absent) else $error("flags 2 absent bit");

  // Absent bits of flags 3 stay low
  property p_flags3_absent;
    (flags_3 & ~IMPL_FLAGS_3) == RESET_REG;
  endproperty
  a_flags3_absent: assert property (p_flags3_absent) else $error("flags 3 absent bit");

  // Absent bits of flags 4 stay low
  property p_flags4_absent;
    (flags_4 & ~IMPL_FLAGS_4) == RESET_REG;
  endproperty
  a_flags4_absent: assert property (p_flags4_absent) else $error("flags 4 absent bit");

  // Enable bits 15 and 14 never set
  property p_enable_top;
    enables_0[15:14] == 2'h0;
  endproperty
  a_enable_top: assert property (p_enable_top) else $error("enable 15..14 set");

  // Enable bit 4 never set
  property p_enable_gap;
    !enables_0[4];
  endproperty
  a_enable_gap: assert property (p_enable_gap) else $error("enable 4 set");

  // Requests 0 and 1 follow flag and enable one cycle later
  property p_req_pair;
    req_1 == ($past(flags_1) & $past(ext_enables_1)) &&
      req_0 == ($past(ext_flags_0) & $past(enables_0));
  endproperty
  a_req_pair: assert property (p_req_pair) else $error("request pairing wrong");

  // Unmasked event raises the interrupt on the next edge
  property p_irq_event;
    (events & state_next.irq_mask) != RESET_IRQ |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("interrupt missed");

endmodule
`default_nettype wire
